// file: hdl/clock_dist_pkg.sv
// Package with register map, field layout and source encodings of the clock distribution block.
package clock_dist_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CTRL_W = 9;
  localparam int STATUS_W = 2;
  localparam int SYNC_STAGES = 2;

  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h004;
  localparam logic [ADDR_W-1:0] BUS_TICKS_OFFSET = 12'h008;
  localparam int WORD_LSB = 2;

  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;
  localparam logic [STATUS_W-1:0] STATUS_RESET = 2'h0;
  localparam logic [DATA_W-1:0] BUS_TICKS_RESET = 32'h0000_0000;

  localparam int GEN_SEL_LSB = 0;
  localparam int RTC_SEL_LSB = 2;
  localparam int ADC_EXT_BIT = 4;
  localparam int WDOG_LPO_BIT = 5;
  localparam int TPM_SEL_LSB = 6;
  localparam int DEBUG_SELF_BIT = 8;

  localparam logic [1:0] GEN_INTERNAL = 2'h0;
  localparam logic [1:0] GEN_EXTERNAL = 2'h1;
  localparam logic [1:0] GEN_LOOP = 2'h2;
  localparam logic [1:0] RTC_INTERNAL = 2'h0;
  localparam logic [1:0] RTC_EXTERNAL = 2'h1;
  localparam logic [1:0] RTC_LPO = 2'h2;
  localparam logic [1:0] TPM_BUS = 2'h0;
  localparam logic [1:0] TPM_FIXED = 2'h1;
  localparam logic [1:0] TPM_EXT = 2'h2;

  localparam int ST_FF_OVERRUN = 0;
  localparam int ST_EXT_OVERRUN = 1;

  localparam logic [1:0] EXT_MIN_GAP = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int PIN_IRC = 0;
  localparam int PIN_ERC = 1;
  localparam int PIN_LOOP = 2;
  localparam int PIN_FFS = 3;
  localparam int PIN_LPO = 4;
  localparam int PIN_TEXT = 5;
  localparam int PIN_DCO = 6;
  localparam int NUM_PINS = 7;
endpackage

// file: hdl/pin_sync_edge.sv
// Two-flop pin synchroniser with a rising-edge detector behind it.
module pin_sync_edge #(
  parameter int STAGES = clock_dist_pkg::SYNC_STAGES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic pin_in,
  output logic level,
  output logic rise
);
  typedef struct packed {
    logic [STAGES:0] sh;
  } sync_state_t;

  sync_state_t st_reg;
  sync_state_t st_next;

  // The edge compares the last two stages only, never the first flop.
  always_comb begin
    st_next = st_reg;
    st_next.sh = {st_reg.sh[STAGES-1:0], pin_in};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.sh[STAGES-1];
  assign rise = st_reg.sh[STAGES-1] & ~st_reg.sh[STAGES];
endmodule

// file: hdl/clock_distribution.sv
// System clock distribution: source selection, bus divider, timer clocks and register slave.
// Behaviour
// R01: Generator output clocks core, USB memory, USB.
// R02: Bus clock is generator output halved.
// R03: Generator output takes exactly one of three sources.
// R04: Peripheral registers step on the bus clock.
// R05: Fixed timer clock: synchronise source, then halve.
// R06: Fixed timer clock never exceeds half bus.
// R07: Fixed timer clock selectable for timer modules.
// R08: External timer input stays below quarter bus; faster edges still pass and only set the external overrun status bit.
// R09: Self clock from oscillator selectable for debug.
// R10: Internal reference selectable for real-time counter.
// R11: External reference selectable for counter and converter.
// R12: Independent low-power clock for counter or watchdog.
// R13: External timer input synchronised, edges found on bus.
module clock_distribution (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic internal_reference_clock,
  input wire logic external_reference_clock,
  input wire logic loop_output_clock,
  input wire logic generator_fixed_freq_source,
  input wire logic low_power_oscillator_clock,
  input wire logic timer_external_clock_input,
  input wire logic digitally_controlled_oscillator,
  output logic clock_generator_output,
  output logic cpu_clock,
  output logic usb_ram_clock,
  output logic usb_clock,
  output logic peripheral_bus_clock,
  output logic peripheral_register_enable,
  output logic fixed_freq_timer_clock,
  output logic timer_clock_enable,
  output logic timer_external_edge,
  output logic rtc_clock,
  output logic adc_clock,
  output logic watchdog_clock,
  output logic debug_interface_clock,
  input wire logic [clock_dist_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [clock_dist_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [clock_dist_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [clock_dist_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int AW = clock_dist_pkg::ADDR_W;
  localparam int DW = clock_dist_pkg::DATA_W;
  localparam int CW = clock_dist_pkg::CTRL_W;
  localparam int SW = clock_dist_pkg::STATUS_W;

  typedef struct packed {
    logic aw_rdy;
    logic aw_have;
    logic [AW-1:0] aw_addr;
    logic w_rdy;
    logic w_have;
    logic [DW-1:0] w_data;
    logic [3:0] w_strb;
    logic b_vld;
    logic [1:0] b_resp;
    logic ar_rdy;
    logic r_vld;
    logic [DW-1:0] r_data;
    logic [1:0] r_resp;
    logic [CW-1:0] ctrl;
    logic [SW-1:0] status;
    logic [DW-1:0] bus_ticks;
    logic gen_out;
    logic bus_div;
    logic bus_tick_out;
    logic ff_pending;
    logic ff_last;
    logic ff_div;
    logic ext_pending;
    logic [1:0] ext_gap;
    logic ext_edge;
    logic timer_tick;
    logic rtc_clk;
    logic adc_clk;
    logic wdog_clk;
    logic dbg_clk;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic [clock_dist_pkg::NUM_PINS-1:0] pins;
  logic [clock_dist_pkg::NUM_PINS-1:0] lvl;
  logic [clock_dist_pkg::NUM_PINS-1:0] rise;

  assign pins[clock_dist_pkg::PIN_IRC] = internal_reference_clock;
  assign pins[clock_dist_pkg::PIN_ERC] = external_reference_clock;
  assign pins[clock_dist_pkg::PIN_LOOP] = loop_output_clock;
  assign pins[clock_dist_pkg::PIN_FFS] = generator_fixed_freq_source;
  assign pins[clock_dist_pkg::PIN_LPO] = low_power_oscillator_clock;
  assign pins[clock_dist_pkg::PIN_TEXT] = timer_external_clock_input;
  assign pins[clock_dist_pkg::PIN_DCO] = digitally_controlled_oscillator;

  // Every source arrives unrelated to aclk, so each passes its own synchroniser.
  genvar gi;
  generate
    for (gi = 0; gi < clock_dist_pkg::NUM_PINS; gi++) begin : g_sync
      pin_sync_edge #(
        .STAGES(clock_dist_pkg::SYNC_STAGES)
      ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .pin_in(pins[gi]),
        .level(lvl[gi]),
        .rise(rise[gi])
      ); // [R13]
    end
  endgenerate

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] data,
                                          input logic [3:0] strb);
    logic [DW-1:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  logic [1:0] gen_sel;
  logic [1:0] rtc_sel;
  logic [1:0] tpm_sel;
  logic gen_rise;
  logic gen_lvl;
  logic bus_tick;
  logic ff_seen;
  logic ff_tick;
  logic ext_seen;
  logic [SW-1:0] status_set;
  logic [SW-1:0] status_clr;
  logic [DW-1:0] ctrl_word;
  logic [DW-1:0] status_word;
  logic [DW-1:0] wr_merged;
  logic wr_ctrl;
  logic wr_status;

  always_comb begin
    st_next = st_reg;
    status_set = '0;
    status_clr = '0;
    ff_tick = 1'b0;
    wr_merged = '0;
    wr_ctrl = 1'b0;
    wr_status = 1'b0;
    gen_sel = st_reg.ctrl[clock_dist_pkg::GEN_SEL_LSB +: 2];
    rtc_sel = st_reg.ctrl[clock_dist_pkg::RTC_SEL_LSB +: 2];
    tpm_sel = st_reg.ctrl[clock_dist_pkg::TPM_SEL_LSB +: 2];
    ctrl_word = DW'(st_reg.ctrl);
    status_word = DW'(st_reg.status);

    // The unused fourth code falls back to the loop so one source is always chosen.
    unique case (gen_sel)
      clock_dist_pkg::GEN_INTERNAL: begin
        gen_rise = rise[clock_dist_pkg::PIN_IRC]; // [R03]
        gen_lvl = lvl[clock_dist_pkg::PIN_IRC];
      end
      clock_dist_pkg::GEN_EXTERNAL: begin
        gen_rise = rise[clock_dist_pkg::PIN_ERC]; // [R03]
        gen_lvl = lvl[clock_dist_pkg::PIN_ERC];
      end
      default: begin
        gen_rise = rise[clock_dist_pkg::PIN_LOOP]; // [R03]
        gen_lvl = lvl[clock_dist_pkg::PIN_LOOP];
      end
    endcase
    st_next.gen_out = gen_lvl; // [R01]

    bus_tick = gen_rise & ~st_reg.bus_div;
    if (gen_rise) begin
      st_next.bus_div = ~st_reg.bus_div; // [R02]
    end
    st_next.bus_tick_out = bus_tick; // [R04]
    if (bus_tick) begin
      st_next.bus_ticks = st_reg.bus_ticks + 32'h0000_0001;
    end

    // Source edges are held until the next bus tick, which is the synchronisation point.
    ff_seen = st_reg.ff_pending | rise[clock_dist_pkg::PIN_FFS];
    st_next.ff_pending = ff_seen;
    if (bus_tick) begin
      st_next.ff_pending = 1'b0;
      if (ff_seen && st_reg.ff_last) begin
        st_next.ff_last = 1'b0; // [R06]
        status_set[clock_dist_pkg::ST_FF_OVERRUN] = 1'b1;
      end else if (ff_seen) begin
        st_next.ff_last = 1'b1;
        st_next.ff_div = ~st_reg.ff_div; // [R05]
        ff_tick = ~st_reg.ff_div;
      end else begin
        st_next.ff_last = 1'b0;
      end
    end
    ext_seen = st_reg.ext_pending | rise[clock_dist_pkg::PIN_TEXT];
    st_next.ext_pending = ext_seen;
    st_next.ext_edge = bus_tick & ext_seen; // [R13]
    if (bus_tick) begin
      st_next.ext_pending = 1'b0;
      if (ext_seen) begin
        st_next.ext_gap = '0;
        if (st_reg.ext_gap < clock_dist_pkg::EXT_MIN_GAP) begin
          status_set[clock_dist_pkg::ST_EXT_OVERRUN] = 1'b1; // [R08]
        end
      end else if (st_reg.ext_gap != clock_dist_pkg::EXT_MIN_GAP) begin
        st_next.ext_gap = st_reg.ext_gap + 2'h1;
      end
    end
    unique case (tpm_sel)
      clock_dist_pkg::TPM_FIXED: st_next.timer_tick = ff_tick; // [R07]
      clock_dist_pkg::TPM_EXT: st_next.timer_tick = bus_tick & ext_seen;
      default: st_next.timer_tick = bus_tick;
    endcase
    unique case (rtc_sel)
      clock_dist_pkg::RTC_INTERNAL: st_next.rtc_clk = lvl[clock_dist_pkg::PIN_IRC]; // [R10]
      clock_dist_pkg::RTC_EXTERNAL: st_next.rtc_clk = lvl[clock_dist_pkg::PIN_ERC]; // [R11]
      default: st_next.rtc_clk = lvl[clock_dist_pkg::PIN_LPO]; // [R12]
    endcase
    st_next.adc_clk = st_reg.ctrl[clock_dist_pkg::ADC_EXT_BIT] ?
                      lvl[clock_dist_pkg::PIN_ERC] : st_reg.bus_div; // [R11]
    st_next.wdog_clk = st_reg.ctrl[clock_dist_pkg::WDOG_LPO_BIT] ?
                       lvl[clock_dist_pkg::PIN_LPO] : st_reg.bus_div; // [R12]
    st_next.dbg_clk = st_reg.ctrl[clock_dist_pkg::DEBUG_SELF_BIT] ?
                      lvl[clock_dist_pkg::PIN_DCO] : st_reg.bus_div; // [R09]

    if (s_axi_awvalid && st_reg.aw_rdy) begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.w_rdy) begin
      st_next.w_have = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.aw_have && st_reg.w_have && !st_reg.b_vld) begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.b_vld = 1'b1;
      st_next.b_resp = clock_dist_pkg::RESP_OKAY;
      unique case (st_reg.aw_addr[AW-1:clock_dist_pkg::WORD_LSB])
        clock_dist_pkg::CTRL_OFFSET[AW-1:clock_dist_pkg::WORD_LSB]: begin
          wr_ctrl = 1'b1;
          wr_merged = merge(ctrl_word, st_reg.w_data, st_reg.w_strb);
        end
        clock_dist_pkg::STATUS_OFFSET[AW-1:clock_dist_pkg::WORD_LSB]: begin
          wr_status = 1'b1;
          wr_merged = merge('0, st_reg.w_data, st_reg.w_strb);
        end
        clock_dist_pkg::BUS_TICKS_OFFSET[AW-1:clock_dist_pkg::WORD_LSB]: ; // Read-only count.
        default: st_next.b_resp = clock_dist_pkg::RESP_SLVERR;
      endcase
    end
    if (st_reg.b_vld && s_axi_bready) begin
      st_next.b_vld = 1'b0;
    end
    if (wr_ctrl) begin
      st_next.ctrl = wr_merged[CW-1:0];
    end
    if (wr_status) begin
      status_clr = wr_merged[SW-1:0];
    end
    // A hardware event in the clearing cycle survives the write-one-to-clear.
    st_next.status = (st_reg.status & ~status_clr) | status_set;
    if (s_axi_arvalid && st_reg.ar_rdy) begin
      st_next.r_vld = 1'b1;
      st_next.r_resp = clock_dist_pkg::RESP_OKAY;
      st_next.r_data = '0;
      unique case (s_axi_araddr[AW-1:clock_dist_pkg::WORD_LSB])
        clock_dist_pkg::CTRL_OFFSET[AW-1:clock_dist_pkg::WORD_LSB]: st_next.r_data = ctrl_word;
        clock_dist_pkg::STATUS_OFFSET[AW-1:clock_dist_pkg::WORD_LSB]: st_next.r_data = status_word;
        clock_dist_pkg::BUS_TICKS_OFFSET[AW-1:clock_dist_pkg::WORD_LSB]: begin
          st_next.r_data = st_reg.bus_ticks;
        end
        default: st_next.r_resp = clock_dist_pkg::RESP_SLVERR;
      endcase
    end else if (st_reg.r_vld && s_axi_rready) begin
      st_next.r_vld = 1'b0;
    end

    // Only one write and one read are in flight, so ready drops until the answer is taken.
    st_next.aw_rdy = ~st_next.aw_have & ~st_next.b_vld;
    st_next.w_rdy = ~st_next.w_have & ~st_next.b_vld;
    st_next.ar_rdy = ~st_next.r_vld;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.ctrl <= clock_dist_pkg::CTRL_RESET;
      st_reg.status <= clock_dist_pkg::STATUS_RESET;
      st_reg.bus_ticks <= clock_dist_pkg::BUS_TICKS_RESET;
      st_reg.ext_gap <= clock_dist_pkg::EXT_MIN_GAP;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign clock_generator_output = st_reg.gen_out;
  assign cpu_clock = st_reg.gen_out;
  assign usb_ram_clock = st_reg.gen_out;
  assign usb_clock = st_reg.gen_out;
  assign peripheral_bus_clock = st_reg.bus_div;
  assign peripheral_register_enable = st_reg.bus_tick_out;
  assign fixed_freq_timer_clock = st_reg.ff_div;
  assign timer_clock_enable = st_reg.timer_tick;
  assign timer_external_edge = st_reg.ext_edge;
  assign rtc_clock = st_reg.rtc_clk;
  assign adc_clock = st_reg.adc_clk;
  assign watchdog_clock = st_reg.wdog_clk;
  assign debug_interface_clock = st_reg.dbg_clk;
  assign s_axi_awready = st_reg.aw_rdy;
  assign s_axi_wready = st_reg.w_rdy;
  assign s_axi_bresp = st_reg.b_resp;
  assign s_axi_bvalid = st_reg.b_vld;
  assign s_axi_arready = st_reg.ar_rdy;
  assign s_axi_rdata = st_reg.r_data;
  assign s_axi_rresp = st_reg.r_resp;
  assign s_axi_rvalid = st_reg.r_vld;
endmodule

// file: sim/clock_distribution_asserts.sv
// Concurrent checks on the ports of the clock distribution block.
module clock_distribution_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clock_generator_output,
  input wire logic cpu_clock,
  input wire logic usb_ram_clock,
  input wire logic usb_clock,
  input wire logic peripheral_bus_clock,
  input wire logic peripheral_register_enable,
  input wire logic fixed_freq_timer_clock,
  input wire logic timer_clock_enable,
  input wire logic timer_external_edge,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [clock_dist_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_gen_fanout: assert property (cpu_clock == clock_generator_output &&
    usb_ram_clock == clock_generator_output && usb_clock == clock_generator_output)
    else $error("core or usb clock differs from generator output");
  a_bus_half: assert property ($changed(peripheral_bus_clock) |=>
    $stable(peripheral_bus_clock)) else $error("bus clock toggled twice in a row");
  a_tick_gap: assert property (peripheral_register_enable |=>
    !peripheral_register_enable [*3]) else $error("bus ticks closer than four cycles");
  // Two bus ticks at least lie between toggles, so eight cycles is a safe floor.
  a_ff_slow: assert property ($changed(fixed_freq_timer_clock) |=>
    $stable(fixed_freq_timer_clock) [*7]) else $error("fixed clock faster than half bus");
  a_tick_pulse: assert property (timer_clock_enable |=> !timer_clock_enable)
    else $error("timer tick longer than one cycle");
  a_ext_gap: assert property (timer_external_edge |=>
    !timer_external_edge [*3]) else $error("external edges not spaced by bus ticks");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped early");
  a_b_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_b_time: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  a_r_time: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  c_ext: cover property (timer_external_edge);
  c_ff: cover property ($rose(fixed_freq_timer_clock));
  c_err: cover property (s_axi_bvalid && s_axi_bresp == clock_dist_pkg::RESP_SLVERR);
endmodule

bind clock_distribution clock_distribution_asserts chk_u (.aclk, .aresetn,
  .clock_generator_output, .cpu_clock, .usb_ram_clock, .usb_clock, .peripheral_bus_clock,
  .peripheral_register_enable, .fixed_freq_timer_clock, .timer_clock_enable,
  .timer_external_edge, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// file: sim/clock_distribution_tb.sv
// Self-checking bench for the clock distribution block.
module clock_distribution_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] CT = clock_dist_pkg::CTRL_OFFSET;
  localparam logic [11:0] ST = clock_dist_pkg::STATUS_OFFSET;
  localparam logic [11:0] BT = clock_dist_pkg::BUS_TICKS_OFFSET;
  localparam logic [1:0] ERR = clock_dist_pkg::RESP_SLVERR;
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
  logic internal_reference_clock = 1'h0, external_reference_clock = 1'h0;
  logic loop_output_clock = 1'h0, generator_fixed_freq_source = 1'h0;
  logic low_power_oscillator_clock = 1'h0, timer_external_clock_input = 1'h0;
  logic digitally_controlled_oscillator = 1'h0;
  logic clock_generator_output, cpu_clock, usb_ram_clock, usb_clock, peripheral_bus_clock;
  logic peripheral_register_enable, fixed_freq_timer_clock, timer_clock_enable;
  logic timer_external_edge, rtc_clock, adc_clock, watchdog_clock, debug_interface_clock;
  logic [clock_dist_pkg::ADDR_W-1:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [clock_dist_pkg::DATA_W-1:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [6:0] cyc = 7'h00;
  logic fast_ff = 1'h0, fast_ext = 1'h0;
  logic [9:0] mon, prv = 10'h000;
  int cnt[10], d[10];
  int err_total = 0, checked = 0;

  clock_distribution dut_u (.aclk, .aresetn, .ce, .internal_reference_clock,
    .external_reference_clock, .loop_output_clock, .generator_fixed_freq_source,
    .low_power_oscillator_clock, .timer_external_clock_input,
    .digitally_controlled_oscillator, .clock_generator_output, .cpu_clock, .usb_ram_clock,
    .usb_clock, .peripheral_bus_clock, .peripheral_register_enable, .fixed_freq_timer_clock,
    .timer_clock_enable, .timer_external_edge, .rtc_clock, .adc_clock, .watchdog_clock,
    .debug_interface_clock, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  initial forever #5 aclk = ~aclk;

  // Source periods in cycles: 8, 16, 4, 32 (4 when fast), 64, 128 (8 when fast), 2.
  always @(posedge aclk) begin
    cyc <= cyc + 7'h01;
    internal_reference_clock <= cyc[2];
    external_reference_clock <= cyc[3];
    loop_output_clock <= cyc[1];
    generator_fixed_freq_source <= fast_ff ? cyc[1] : cyc[4];
    low_power_oscillator_clock <= cyc[5];
    timer_external_clock_input <= fast_ext ? cyc[2] : cyc[6];
    digitally_controlled_oscillator <= cyc[0];
  end

  assign mon = {debug_interface_clock, watchdog_clock, adc_clock, rtc_clock,
    timer_external_edge, timer_clock_enable, peripheral_register_enable,
    fixed_freq_timer_clock, peripheral_bus_clock, clock_generator_output};
  always @(posedge aclk) begin
    prv <= mon;
    for (int i = 0; i < 10; i++) if (mon[i] && !prv[i]) cnt[i]++;
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Phases of the sources drift against the window, so counts may miss by two.
  task automatic near(string nm, int e, int g);
    checked++;
    if (g < e - 2 || g > e + 2) begin
      err_total++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic span(int n);
    int s[10];
    repeat (16) @(posedge aclk);
    s = cnt;
    repeat (n) @(posedge aclk);
    foreach (d[i]) d[i] = cnt[i] - s[i];
  endtask

  function automatic logic [31:0] cfg(logic [1:0] g, logic [1:0] r, logic a, logic w,
                                      logic [1:0] t, logic b);
    return {23'h0, b, t, w, a, r, g};
  endfunction

  // The response is left waiting one cycle so that its hold is exercised.
  task automatic wr(logic [11:0] a, logic [31:0] v, logic [3:0] s, output logic [1:0] r);
    logic aw;
    logic w;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    aw = 1'h0;
    w = 1'h0;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'h1) begin
        aw = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w && s_axi_wready === 1'h1) begin
        w = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'h1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    @(posedge aclk);
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic t_regs();
    logic [31:0] v;
    logic [31:0] v0;
    logic [1:0] r;
    rd(CT, v, r);
    chk("ctrl_reset", 32'h0, v);
    rd(ST, v, r);
    chk("status_reset", 32'h0, v);
    rd(12'h00c, v, r);
    chk("rd_hole_resp", {30'h0, ERR}, {30'h0, r});
    chk("rd_hole_data", 32'h0, v);
    wr(12'h00c, 32'hffff_ffff, 4'hf, r);
    chk("wr_hole_resp", {30'h0, ERR}, {30'h0, r});
    wr(CT, 32'h1ff, 4'h1, r);
    rd(CT, v, r);
    chk("ctrl_strobe", 32'h0ff, v);
    rd(BT, v0, r);
    span(256);
    wr(BT, 32'h0, 4'hf, r);
    chk("ticks_wr_resp", 32'h0, {30'h0, r});
    rd(BT, v, r);
    near("ticks_count", 35, int'(v - v0));
  endtask

  task automatic t_gen();
    logic [1:0] r;
    int p;
    for (int g = 0; g < 4; g++) begin
      p = g == 0 ? 8 : g == 1 ? 16 : 4;
      wr(CT, cfg(g[1:0], 2'h0, 1'h0, 1'h0, 2'h0, 1'h0), 4'hf, r);
      span(256);
      near("gen_rate", 256 / p, d[0]);
      near("bus_rate", 128 / p, d[1]);
      near("tick_rate", d[1], d[3]);
    end
  endtask

  task automatic t_timer();
    logic [31:0] v;
    logic [1:0] r;
    // A fixed source at twice the bus rate in the generator scenario flags an overrun.
    wr(ST, 32'h3, 4'hf, r);
    for (int m = 0; m < 4; m++) begin
      wr(CT, cfg(2'h2, 2'h0, 1'h0, 1'h0, m[1:0], 1'h0), 4'hf, r);
      span(512);
      near("ff_rate", 8, d[2]);
      near("ext_rate", 4, d[5]);
      near("timer_tick", m == 1 ? 8 : m == 2 ? 4 : 64, d[4]);
    end
    rd(ST, v, r);
    chk("status_quiet", 32'h0, v);
    fast_ff <= 1'h1;
    span(256);
    rd(ST, v, r);
    chk("ff_overrun", 32'h1, v);
    chk("ff_half_bus", 32'h1, {31'h0, d[2] <= d[1] / 2 + 1});
    fast_ff <= 1'h0;
    repeat (64) @(posedge aclk);
    wr(ST, 32'h1, 4'hf, r);
    rd(ST, v, r);
    chk("ff_clear", 32'h0, v);
    fast_ext <= 1'h1;
    span(256);
    rd(ST, v, r);
    chk("ext_overrun", 32'h2, v);
    near("ext_passed", 32, d[5]);
    fast_ext <= 1'h0;
    repeat (64) @(posedge aclk);
    wr(ST, 32'h2, 4'hf, r);
    rd(ST, v, r);
    chk("ext_clear", 32'h0, v);
  endtask

  task automatic t_sel();
    logic [1:0] r;
    for (int k = 0; k < 4; k++) begin
      wr(CT, cfg(2'h2, k[1:0], 1'h1, 1'h1, 2'h0, 1'h1), 4'hf, r);
      span(256);
      near("rtc_src", k == 0 ? 32 : k == 1 ? 16 : 4, d[6]);
      near("adc_ext", 16, d[7]);
      near("wdog_lpo", 4, d[8]);
      near("debug_self", 128, d[9]);
    end
    wr(CT, cfg(2'h2, 2'h0, 1'h0, 1'h0, 2'h0, 1'h0), 4'hf, r);
    span(256);
    near("adc_bus", d[1], d[7]);
    near("wdog_bus", d[1], d[8]);
    near("debug_bus", d[1], d[9]);
    // Freeze right after a bus tick so that no one-cycle pulse is held high.
    do @(posedge aclk); while (peripheral_register_enable !== 1'h1);
    ce <= 1'h0;
    span(64);
    chk("ce_freeze", 32'h0, d[1]);
    ce <= 1'h1;
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_gen();
    t_timer();
    t_sel();
    summarize();
  end

  initial begin
    repeat (30000) @(posedge aclk);
    err_total++;
    $display("[FAIL] run expected done seen timeout");
    summarize();
  end
endmodule
